// >>> cbs_clock_buffer_ctrl.sv
/*
 * Control logic of an eight-output reference clock buffer: serial management
 * slave, per-output gating, strapped slave address, power-good / power-down.
 * Assumes i_clk_sys far faster than the reference clock, which is sampled as
 * an ordinary asynchronous input; the bus host drives the clock line.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - registers reachable through an SMBus 2.0 compliant slave
// - one reference clock is replicated onto up to eight gated outputs
// - each active-low enable pin gates only the output with its index
// - while an enable pin is low, its register bit decides the output
// - the slave answers only while the power pin is at 1
// - with the power pin at 0 the bus pins are released
// - power-down leaves every register value untouched
// - slave address comes from two three-level straps, nine choices
// - write addresses D8 DA DE C2 C4 C6 CA CC CE; read is plus one
// - straps are sampled when power-good becomes 1
// - captured address holds until power is cycled
// - power-good latch and power-down request both come from one pin
// - first rising edge on the power pin sets power-good
// - afterwards a low pin level requests power-down, high releases it
// - nothing but supply removal clears power-good
// - bus clock low for 1e6 reference cycles is a timeout
// - command bit 7: 0 block, 1 single byte; bits 6:0 address
// - an output runs only with its bit at 1 and its pin low
// - output stops within ten reference periods after its pin rises
module cbs_clock_buffer_ctrl #(
    parameter int NUM_CH             = cbs_pkg::CBS_NUM_CH,
    parameter int TIMEOUT_REF_CYCLES = cbs_pkg::CBS_REF_TIMEOUT_CYCLES
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire logic              i_reference_input_clock,
    input  wire logic              i_power_good_power_down_pin,
    input  wire logic [1:0]        i_address_strap_0,
    input  wire logic [1:0]        i_address_strap_1,
    input  wire logic [NUM_CH-1:0] i_output_enable_n,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda,
    output logic                   o_sda_oe,
    output logic [NUM_CH-1:0]      o_clock_output_channels,
    output logic [NUM_CH-1:0]      o_channel_run,
    output logic                   o_power_good_latch,
    output logic                   o_power_down_request,
    output logic [7:0]             o_slave_address,
    output logic                   o_bus_timeout
);

    localparam int W  = NUM_CH + 8;
    localparam int TW = $clog2(TIMEOUT_REF_CYCLES + 1);
    localparam int RW = $clog2(cbs_pkg::CBS_NREG);

    generate
        if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
            $error("NUM_CH must lie between 1 and 8");
        end
        if (TIMEOUT_REF_CYCLES < 2) begin : g_bad_to
            $error("TIMEOUT_REF_CYCLES must be at least 2");
        end
    endgenerate

    // every pin but the reset enters through two flip-flops before anything reads it
    logic [W-1:0] sync_q;

    cbs_sync #(
        .WIDTH (W)
    ) u_sync (
        .i_clk   (i_clk_sys),
        .i_rst_n (i_rst_n),
        .i_async ({i_reference_input_clock, i_power_good_power_down_pin,
                   i_address_strap_1, i_address_strap_0, i_output_enable_n,
                   i_scl, i_sda}),
        .o_sync  (sync_q)
    );

    wire              sda_s = sync_q[0];
    wire              scl_s = sync_q[1];
    wire [NUM_CH-1:0] oe_s  = sync_q[NUM_CH+1:2];
    wire [1:0]        s0_s  = sync_q[NUM_CH+3:NUM_CH+2];
    wire [1:0]        s1_s  = sync_q[NUM_CH+5:NUM_CH+4];
    wire              pin_s = sync_q[NUM_CH+6];
    wire              ref_s = sync_q[NUM_CH+7];

    logic ref_q;
    logic pin_q;
    logic scl_q;
    logic sda_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ref_q <= 1'b0;
            pin_q <= 1'b0;
            scl_q <= 1'b0;
            sda_q <= 1'b0;
        end else begin
            ref_q <= ref_s;
            pin_q <= pin_s;
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // power state variables
    wire pin_rise = pin_s & ~pin_q;
    wire pg_set   = pin_rise & ~o_power_good_latch;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_power_good_latch <= 1'b0;
        end else if (pg_set) begin
            o_power_good_latch <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_power_down_request <= 1'b0;
        end else if (o_power_good_latch || pg_set) begin
            o_power_down_request <= ~pin_s;
        end
    end

    // strap capture; only a power cycle reopens it
    logic [1:0] s0_lat;
    logic [1:0] s1_lat;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s0_lat <= cbs_pkg::CBS_STRAP_LOW;
            s1_lat <= cbs_pkg::CBS_STRAP_LOW;
        end else if (pg_set) begin
            s0_lat <= s0_s;
            s1_lat <= s1_s;
        end
    end

    // the unused fourth code is read as high
    wire [1:0] s0_c     = (s0_lat == 2'h3) ? cbs_pkg::CBS_STRAP_HIGH : s0_lat;
    wire [1:0] s1_c     = (s1_lat == 2'h3) ? cbs_pkg::CBS_STRAP_HIGH : s1_lat;
    wire [3:0] addr_idx = 4'({2'h0, s1_c} * 4'h3) + {2'h0, s0_c};

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_slave_address <= cbs_pkg::CBS_ADDR_TAB[0];
        end else begin
            o_slave_address <= cbs_pkg::CBS_ADDR_TAB[addr_idx];
        end
    end

    // the slave only listens with power-good set and the pin high
    wire bus_active = o_power_good_latch & pin_s;

    // timeout counts reference clock edges while the bus clock is low
    logic [TW-1:0] to_cnt;

    wire ref_rise = ref_s & ~ref_q;
    wire to_hit   = bus_active & ~scl_s & ref_rise
                  & (to_cnt == TW'(TIMEOUT_REF_CYCLES - 1));

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !bus_active || scl_s || to_hit) begin
            to_cnt <= '0;
        end else if (ref_rise) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_bus_timeout <= 1'b0;
        end else begin
            o_bus_timeout <= to_hit;
        end
    end

    // bus conditions
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    cbs_pkg::cbs_state_e state;
    cbs_pkg::cbs_kind_e  kind;
    logic [3:0]          bitcnt;
    logic [7:0]          shreg;
    logic [7:0]          cmd;
    logic [6:0]          ptr;
    logic                rw;
    logic                first;
    logic                nack;
    logic [7:0]          regs [0:cbs_pkg::CBS_NREG-1];

    wire is_block   = ~cmd[cbs_pkg::CBS_CMD_BYTE_BIT];
    wire byte_done  = scl_fall & (bitcnt == 4'h8);
    wire addr_match = shreg[7:1] == o_slave_address[7:1];
    wire ptr_in_map = ptr < 7'(cbs_pkg::CBS_NREG);
    wire ptr_is_rb  = ptr == cbs_pkg::CBS_REG_OE_READBACK;

    // block transfers carry a byte count ahead of the data
    wire tx_is_count = is_block & first;
    wire [7:0] rd_byte = tx_is_count ? cbs_pkg::CBS_BLOCK_COUNT :
                         ptr_is_rb   ? 8'(oe_s) :
                         ptr_in_map  ? regs[ptr[RW-1:0]] : 8'h00;

    wire wr_en = (state == cbs_pkg::CBS_ST_RX) & (kind == cbs_pkg::CBS_KIND_DATA)
               & byte_done & ~(is_block & first) & ptr_in_map & ~ptr_is_rb;

    wire load_tx = ((state == cbs_pkg::CBS_ST_ACK) & scl_fall & rw
                    & (kind == cbs_pkg::CBS_KIND_ADDR))
                 | ((state == cbs_pkg::CBS_ST_RXACK) & scl_fall & ~nack);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !bus_active || to_hit) begin
            state    <= cbs_pkg::CBS_ST_IDLE;
            kind     <= cbs_pkg::CBS_KIND_ADDR;
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
        end else if (start_c) begin
            state    <= cbs_pkg::CBS_ST_RX;
            kind     <= cbs_pkg::CBS_KIND_ADDR;
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
        end else if (stop_c) begin
            state    <= cbs_pkg::CBS_ST_IDLE;
            o_sda_oe <= 1'b0;
        end else if (load_tx) begin
            state    <= cbs_pkg::CBS_ST_TX;
            shreg    <= rd_byte;
            o_sda_oe <= ~rd_byte[7];
            bitcnt   <= 4'h1;
        end else begin
            case (state)
                cbs_pkg::CBS_ST_RX: begin
                    if (scl_rise) begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (byte_done) begin
                        bitcnt <= 4'h0;
                        if (kind == cbs_pkg::CBS_KIND_ADDR && !addr_match) begin
                            state <= cbs_pkg::CBS_ST_IDLE;
                        end else begin
                            state    <= cbs_pkg::CBS_ST_ACK;
                            o_sda_oe <= 1'b1;
                        end
                        if (kind == cbs_pkg::CBS_KIND_ADDR) begin
                            rw <= shreg[0];
                        end
                    end
                end
                cbs_pkg::CBS_ST_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        state    <= cbs_pkg::CBS_ST_RX;
                        if (kind == cbs_pkg::CBS_KIND_ADDR) begin
                            kind <= cbs_pkg::CBS_KIND_CMD;
                        end else begin
                            kind <= cbs_pkg::CBS_KIND_DATA;
                        end
                    end
                end
                cbs_pkg::CBS_ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            o_sda_oe <= 1'b0;
                            state    <= cbs_pkg::CBS_ST_RXACK;
                        end else begin
                            o_sda_oe <= ~shreg[6];
                            shreg    <= {shreg[6:0], 1'b0};
                            bitcnt   <= bitcnt + 4'h1;
                        end
                    end
                end
                cbs_pkg::CBS_ST_RXACK: begin
                    if (scl_fall) begin
                        state <= cbs_pkg::CBS_ST_IDLE;
                    end
                end
                default: begin
                    state <= cbs_pkg::CBS_ST_IDLE;
                end
            endcase
        end
    end

    // command, pointer and block bookkeeping, kept apart from the line driver
    wire rx_done  = (state == cbs_pkg::CBS_ST_RX) & byte_done & bus_active & ~to_hit;
    wire addr_rd  = rx_done & (kind == cbs_pkg::CBS_KIND_ADDR) & addr_match & shreg[0];
    wire cmd_done = rx_done & (kind == cbs_pkg::CBS_KIND_CMD);
    wire dat_done = rx_done & (kind == cbs_pkg::CBS_KIND_DATA);
    wire tx_step  = load_tx & bus_active & ~to_hit & ~start_c & ~stop_c;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmd   <= 8'h00;
            ptr   <= 7'h00;
            first <= 1'b0;
        end else if (cmd_done) begin
            cmd   <= shreg;
            ptr   <= shreg[6:0];
            first <= ~shreg[cbs_pkg::CBS_CMD_BYTE_BIT];
        end else if (addr_rd) begin
            first <= is_block;
        end else if ((dat_done || tx_step) && first && is_block) begin
            first <= 1'b0;
        end else if (dat_done || tx_step) begin
            ptr <= ptr + 7'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            nack <= 1'b0;
        end else if (state == cbs_pkg::CBS_ST_RXACK && scl_rise) begin
            nack <= sda_s;
        end
    end

    // registers take their reset values (enable FF, others 00) only on reset, never on power-down
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int i = 0; i < cbs_pkg::CBS_NREG; i++) begin
                regs[i] <= (7'(i) == cbs_pkg::CBS_REG_ENABLE) ?
                           cbs_pkg::CBS_ENABLE_RESET : cbs_pkg::CBS_REG_RESET;
            end
        end else if (wr_en) begin
            regs[ptr[RW-1:0]] <= shreg;
        end
    end

    // output gating; pin to stop is three system cycles, far inside ten periods
    wire [NUM_CH-1:0] en_bits  = regs[cbs_pkg::CBS_REG_ENABLE[RW-1:0]][NUM_CH-1:0];
    wire [NUM_CH-1:0] next_run = {NUM_CH{o_power_good_latch & ~o_power_down_request}}
                               & en_bits & ~oe_s;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_channel_run           <= '0;
            o_clock_output_channels <= '0;
            o_sda                   <= 1'b0;
        end else begin
            o_channel_run           <= next_run;
            o_clock_output_channels <= next_run & {NUM_CH{ref_s}};
            o_sda                   <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> cbs_clock_buffer_ctrl_chk.sv
/*
 * Port-level assertions for the clock buffer control block.
 * Assumes a bind from the test top and a reference clock far slower than i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module cbs_clock_buffer_ctrl_chk #(
    parameter int NUM_CH             = 8,
    parameter int TIMEOUT_REF_CYCLES = 1000000
) (
    input wire logic              i_clk_sys,
    input wire logic              i_rst_n,
    input wire logic              i_reference_input_clock,
    input wire logic              i_power_good_power_down_pin,
    input wire logic [NUM_CH-1:0] i_output_enable_n,
    input wire logic              i_scl,
    input wire logic              o_sda_oe,
    input wire logic [NUM_CH-1:0] o_clock_output_channels,
    input wire logic [NUM_CH-1:0] o_channel_run,
    input wire logic              o_power_good_latch,
    input wire logic              o_power_down_request,
    input wire logic [7:0]        o_slave_address,
    input wire logic              o_bus_timeout
);
    logic [NUM_CH-1:0] oe_high;
    logic              ref_q;
    // reference rising edges seen since the bus clock last stood high
    int                ref_low;
    // pin high on the last three samples, which covers the two-stage sync delay
    always_ff @(posedge i_clk_sys) begin
        oe_high <= i_output_enable_n & $past(i_output_enable_n) & $past(i_output_enable_n, 2);
        ref_q   <= i_reference_input_clock;
        ref_low <= i_scl ? 0 : ref_low + int'(i_reference_input_clock & !ref_q);
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    AST_LATCH_HOLD: assert property (o_power_good_latch |=> o_power_good_latch)
        else $error("power good latch cleared");
    AST_LATCH_SET: assert property ($rose(i_power_good_power_down_pin) |-> ##[1:4] o_power_good_latch)
        else $error("power good latch not set");
    AST_ADDR_HOLD: assert property ($past(o_power_good_latch, 2) |-> $stable(o_slave_address))
        else $error("slave address changed");
    AST_ADDR_TABLE: assert property (o_slave_address inside {8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE})
        else $error("slave address out of table");
    AST_PD_SET: assert property ((o_power_good_latch && !i_power_good_power_down_pin) [*5] |-> o_power_down_request)
        else $error("power down not requested");
    AST_PD_CLR: assert property (i_power_good_power_down_pin [*5] |-> !o_power_down_request)
        else $error("power down not released");
    AST_RUN_PIN: assert property ((o_channel_run & oe_high) == '0)
        else $error("output runs with its pin high");
    AST_RUN_POWER: assert property ((!o_power_good_latch || o_power_down_request) [*2] |-> o_channel_run == '0)
        else $error("output runs while powered down");
    AST_CLK_GATE: assert property ((o_channel_run == '0) [*2] |-> o_clock_output_channels == '0)
        else $error("clock on a stopped output");
    AST_BUS_OFF: assert property (!i_power_good_power_down_pin [*5] |-> !o_sda_oe)
        else $error("data driven with power pin low");
    AST_SDA_MOVE: assert property ($rose(o_sda_oe) || $fell(o_sda_oe) |-> !i_scl)
        else $error("data moved while bus clock high");
    AST_TO_WAIT: assert property (o_bus_timeout |-> ref_low >= TIMEOUT_REF_CYCLES)
        else $error("timeout too early");
    AST_TO_FREE: assert property (o_bus_timeout |-> ##[0:2] !o_sda_oe)
        else $error("data line held after timeout");
endmodule
`default_nettype wire

// >>> cbs_clock_buffer_ctrl_test.sv
/*
 * Self-checking bench for the clock buffer control block with a host model.
 * Assumes cbs_host.sv and the checker file are compiled before this one.
 */
`timescale 1ns/10ps
`default_nettype none
module cbs_clock_buffer_ctrl_test;
    localparam int TO_REF = 20;
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_reference_input_clock = 1'b0;
    logic        i_power_good_power_down_pin = 1'b0;
    logic [1:0]  i_address_strap_0 = 2'h0;
    logic [1:0]  i_address_strap_1 = 2'h0;
    logic [7:0]  i_output_enable_n = 8'h00;
    wire logic   i_scl;
    wire logic   i_sda;
    wire logic   host_low;
    logic        o_sda, o_sda_oe, o_power_good_latch, o_power_down_request, o_bus_timeout;
    logic [7:0]  o_clock_output_channels, o_channel_run, o_slave_address, addr, v;
    logic [15:0] q;
    logic [7:0]  ck_or, ck_and;
    logic        nak;
    int          n_mismatch = 0;
    int          compares = 0;
    int          seed = 16138;
    int          to_seen = 0;
    int          mreg [8] = '{0, 255, 0, 0, 0, 0, 0, 0};
    logic [7:0]  atab [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};

    always #5 i_clk_sys = ~i_clk_sys;
    // reference clock never stops, before or after power-down requests
    initial #37 forever #80 i_reference_input_clock = ~i_reference_input_clock;
    assign i_sda = !(host_low || o_sda_oe);
    always @(posedge i_clk_sys) if (o_bus_timeout === 1'b1) to_seen = 1;

    cbs_clock_buffer_ctrl #(.TIMEOUT_REF_CYCLES(TO_REF)) dut (.i_clk_sys, .i_rst_n,
        .i_reference_input_clock, .i_power_good_power_down_pin, .i_address_strap_0,
        .i_address_strap_1, .i_output_enable_n, .i_scl, .i_sda, .o_sda, .o_sda_oe,
        .o_clock_output_channels, .o_channel_run, .o_power_good_latch,
        .o_power_down_request, .o_slave_address, .o_bus_timeout);
    cbs_host host (.i_clk(i_clk_sys), .i_sda(i_sda), .o_scl(i_scl), .o_sda_low(host_low));

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        for (int s = 0; s < 9; s++) begin
            i_rst_n = 1'b0;
            i_power_good_power_down_pin = 1'b0;
            // the unused code 11 must read as high
            i_address_strap_1 = (s == 8) ? 2'h3 : 2'(s / 3);
            i_address_strap_0 = 2'(s % 3);
            wait_n(16);
            i_rst_n = 1'b1;
            wait_n(4);
            i_power_good_power_down_pin = 1'b1;
            wait_n(8);
            addr = atab[s];
            check("address", {o_power_good_latch, o_slave_address}, {1'b1, addr});
            i_address_strap_0 = 2'({$random(seed)} % 3);
            i_power_good_power_down_pin = 1'b0;
            wait_n(8);
            check("power down", {o_power_good_latch, o_power_down_request}, 2'b11);
            i_power_good_power_down_pin = 1'b1;
            wait_n(8);
            check("recovered", {o_power_down_request, o_slave_address}, {1'b0, addr});
        end
        $display("test straps done");
        for (int i = 0; i < 5; i++) begin
            v = 8'($random(seed));
            i_output_enable_n = 8'($random(seed));
            host.wr(addr, 8'h81, v, nak);
            mreg[1] = v;
            wait_n(6);
            check("run", {nak, o_channel_run}, {1'b0, 8'(mreg[1]) & ~i_output_enable_n});
            ck_or = 8'h00;
            ck_and = 8'hFF;
            repeat (20) begin
                @(negedge i_clk_sys);
                ck_or = ck_or | o_clock_output_channels;
                ck_and = ck_and & o_clock_output_channels;
            end
            check("clock out", {ck_or, ck_and}, {8'(mreg[1]) & ~i_output_enable_n, 8'h00});
        end
        v = 8'($random(seed));
        host.wr(addr, 8'h82, v, nak);
        mreg[2] = v;
        // block write carrying only its count byte must leave the registers alone
        host.wr(addr, 8'h02, 8'h05, nak);
        check("block count", nak, 1'b0);
        host.rd(addr, 8'h83, q, nak);
        check("pin readback", {nak, q}, {1'b0, i_output_enable_n, 8'(mreg[4])});
        host.rd(addr, 8'h81, q, nak);
        check("byte read", {nak, q}, {1'b0, 8'(mreg[1]), 8'(mreg[2])});
        host.rd(addr, 8'h01, q, nak);
        check("block read", {nak, q}, {1'b0, 8'h08, 8'(mreg[1])});
        $display("test bus done");
        i_power_good_power_down_pin = 1'b0;
        wait_n(8);
        host.wr(addr, 8'h81, 8'h00, nak);
        check("bus off", {nak, o_channel_run}, {1'b1, 8'h00});
        i_power_good_power_down_pin = 1'b1;
        wait_n(8);
        host.rd(addr, 8'h81, q, nak);
        check("kept", {nak, q}, {1'b0, 8'(mreg[1]), 8'(mreg[2])});
        check("run back", o_channel_run, 8'(mreg[1]) & ~i_output_enable_n);
        host.wr(addr ^ 8'h02, 8'h81, 8'h00, nak);
        check("other address", nak, 1'b1);
        $display("test power down done");
        to_seen = 0;
        host.cond(1'b0);
        for (int b = 7; b >= 0; b--) host.bitx(addr[b], nak);
        wait_n(6);
        check("ack held", {to_seen[0], o_sda, o_sda_oe}, 3'b001);
        wait_n(TO_REF * 16 - 60);
        check("no early timeout", to_seen[0], 1'b0);
        wait_n(160);
        check("timeout", {to_seen[0], o_sda_oe}, 2'b10);
        host.cond(1'b1);
        host.rd(addr, 8'h81, q, nak);
        check("after timeout", {nak, q}, {1'b0, 8'(mreg[1]), 8'(mreg[2])});
        $display("test timeout done");
        stop_test();
    end

    initial begin
        // the whole sequence needs about 30k cycles
        repeat (90000) @(posedge i_clk_sys);
        n_mismatch++;
        stop_test();
    end
endmodule

bind cbs_clock_buffer_ctrl cbs_clock_buffer_ctrl_chk #(.NUM_CH(NUM_CH),
    .TIMEOUT_REF_CYCLES(TIMEOUT_REF_CYCLES)) u_chk (.i_clk_sys, .i_rst_n, .i_reference_input_clock,
    .i_power_good_power_down_pin, .i_output_enable_n, .i_scl, .o_sda_oe,
    .o_clock_output_channels, .o_channel_run, .o_power_good_latch,
    .o_power_down_request, .o_slave_address, .o_bus_timeout);
`default_nettype wire

// >>> cbs_host.sv
/*
 * Behavioural bus host for the clock buffer's management port.
 * Assumes the bench resolves the pulled-up data line and feeds it back.
 */
`timescale 1ns/10ps
`default_nettype none
module cbs_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda_low
);
    // about 1.9 MHz, far above a real bus, to keep the run short; the slave has no minimum
    localparam int HALF = 25;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // data moves only while the clock is low, a few cycles after its fall for hold
    task automatic bitx(input logic d, output logic q);
        wt(3);
        o_sda_low = !d;
        wt(HALF);
        o_scl = 1'b1;
        wt(HALF / 2);
        q = i_sda;
        wt(HALF - HALF / 2);
        o_scl = 1'b0;
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bitx(d[i], q[i]);
    endtask
    // start or repeated start when is_stop is 0, stop otherwise
    task automatic cond(input logic is_stop);
        wt(3);
        o_sda_low = is_stop;
        wt(HALF);
        o_scl = 1'b1;
        wt(HALF);
        o_sda_low = !is_stop;
        wt(HALF);
        if (!is_stop) o_scl = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                      output logic nak);
        logic [8:0] q0, q1, q2;
        cond(1'b0);
        xfer({a, 1'b1}, q0);
        xfer({c, 1'b1}, q1);
        xfer({d, 1'b1}, q2);
        cond(1'b1);
        nak = q0[0] | q1[0] | q2[0];
    endtask
    // two bytes read: the first acked, the last refused to end the transfer
    task automatic rd(input logic [7:0] a, input logic [7:0] c, output logic [15:0] q,
                      output logic nak);
        logic [8:0] q0, q1, q2, q3, q4;
        cond(1'b0);
        xfer({a, 1'b1}, q0);
        xfer({c, 1'b1}, q1);
        cond(1'b0);
        xfer({a | 8'h01, 1'b1}, q2);
        xfer(9'h1FE, q3);
        xfer(9'h1FF, q4);
        cond(1'b1);
        q = {q3[8:1], q4[8:1]};
        nak = q0[0] | q1[0] | q2[0];
    endtask
endmodule
`default_nettype wire

// >>> cbs_pkg.sv
/*
 * Shared constants and types for the clock buffer control logic:
 * register indices, reset values, strap codes, address table, timeout count
 * and the serial slave state encoding.
 * Assumes a single system clock domain; all users reference it as cbs_pkg::name.
 */
package cbs_pkg;

    localparam int CBS_NUM_CH = 8;
    localparam int CBS_NREG   = 8;

    // register indices reached through the command byte
    localparam logic [6:0] CBS_REG_ENABLE      = 7'h01;
    localparam logic [6:0] CBS_REG_OE_READBACK = 7'h03;

    localparam logic [7:0] CBS_ENABLE_RESET = 8'hFF;
    localparam logic [7:0] CBS_REG_RESET    = 8'h00;
    localparam logic [7:0] CBS_BLOCK_COUNT  = 8'h08;

    // command byte layout
    localparam int CBS_CMD_BYTE_BIT = 7;

    // bus clock low timeout, in reference clock cycles (1e6)
    localparam int CBS_REF_TIMEOUT_CYCLES = 32'h000F_4240;

    // three-level strap encoding on the two-bit strap ports
    localparam logic [1:0] CBS_STRAP_LOW  = 2'h0;
    localparam logic [1:0] CBS_STRAP_MID  = 2'h1;
    localparam logic [1:0] CBS_STRAP_HIGH = 2'h2;

    // write address per strap pair, index = strap1 * 3 + strap0
    localparam logic [7:0] CBS_ADDR_TAB [0:8] = '{
        8'hD8, 8'hDA, 8'hDE,
        8'hC2, 8'hC4, 8'hC6,
        8'hCA, 8'hCC, 8'hCE
    };

    typedef enum logic [2:0] {
        CBS_ST_IDLE  = 3'b000,
        CBS_ST_RX    = 3'b001,
        CBS_ST_ACK   = 3'b010,
        CBS_ST_TX    = 3'b011,
        CBS_ST_RXACK = 3'b100
    } cbs_state_e;

    typedef enum logic [1:0] {
        CBS_KIND_ADDR = 2'b00,
        CBS_KIND_CMD  = 2'b01,
        CBS_KIND_DATA = 2'b10
    } cbs_kind_e;

endpackage

// >>> cbs_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of asynchronous inputs.
 * Assumes each bit is independent; no bus coherence is offered.
 */
`timescale 1ns/10ps
`default_nettype none

module cbs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule

`default_nettype wire
